// *** hw/pcl_pkg.sv ***
package pcl_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam real         CLK_PERIOD_NS   = 100.0;
    localparam real         STAB_TIME_MS    = 5.39;
    // longest wait: round down to whole cycles
    localparam int          STAB_CYCLES_INT =
        int'($floor(STAB_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int          STAB_CNT_W      = 17;
    localparam logic [16:0] STAB_CYCLES     = STAB_CYCLES_INT[16:0];

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_LEVEL       = 8'h04;
    localparam logic [7:0] OFS_CAUSE       = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK    = 8'h10;
    localparam logic [7:0] OFS_POC_STATUS  = 8'h14;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int         CTRL_EN_BIT     = 7;
    localparam int         CTRL_SRC_BIT    = 2;
    localparam int         CTRL_ACT_BIT    = 1;
    localparam int         CTRL_FLAG_BIT   = 0;
    localparam logic [7:0] CTRL_WR_MASK    = 8'h86;
    localparam int         LEVEL_W         = 4;
    localparam int         CAUSE_WDT_BIT   = 4;
    localparam int         CAUSE_LVD_BIT   = 0;
    localparam int         INT_FALL_BIT    = 0;
    localparam int         INT_RISE_BIT    = 1;
    localparam int         INT_W           = 2;
    localparam int         POC_MODE_BIT    = 0;
    localparam logic [7:0] CTRL_RST        = 8'h00;
    localparam logic [3:0] LEVEL_RST       = 4'h0;
    localparam logic [7:0] CAUSE_RST       = 8'h00;
    localparam logic [1:0] INT_RST         = 2'h0;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        POC_WAIT_LOW,
        POC_STAB,
        POC_RUN
    } pcl_poc_state_type;

    // comparator outputs and reset requests, all asynchronous
    typedef struct packed {
        logic ext_reset_req;
        logic wdt_reset_req;
        logic por_mode_option;
        logic pin_ok;
        logic supply_ok;
        logic por_high_ok;
        logic por_low_ok;
    } pcl_analog_type;

    typedef struct packed {
        pcl_analog_type s1;
        pcl_analog_type s2;
    } pcl_sync_state_type;

    typedef struct packed {
        pcl_poc_state_type       poc_state;
        logic                    por_mode;
        logic [STAB_CNT_W-1:0]   stab_cnt;
        logic [7:0]              ctrl;
        logic [LEVEL_W-1:0]      level;
        logic [7:0]              cause;
        logic [INT_W-1:0]        int_status;
        logic [INT_W-1:0]        int_mask;
        logic                    below_prev;
        logic                    rst_n_out;
        logic                    irq;
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
    } pcl_state_type;

endpackage

// *** hw/pcl_sync.sv ***
`timescale 1ns/1ps

// two-stage synchroniser for every comparator and request line
module pcl_sync
(
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire pcl_pkg::pcl_analog_type d,
    output pcl_pkg::pcl_analog_type      q
);

    pcl_pkg::pcl_sync_state_type state_reg;
    pcl_pkg::pcl_sync_state_type state_next;

    // runs without the clock enable so detection keeps working in stop
    always_comb
    begin
        state_next    = state_reg;
        state_next.s1 = d;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.s2;

endmodule

// *** hw/pcl_top.sv ***
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// R01: low mode holds reset until supply passes low point
// R02: low mode resets below low point, releases above
// R03: dual mode holds reset until high point
// R04: dual mode asserts at low, releases at high
// R05: dual mode inserts stabilisation wait after low point
// R06: source select picks supply or pin comparator
// R07: action select picks reset or interrupt
// R08: reset action, supply below level asserts reset
// R09: reset action, pin below reference asserts reset
// R10: interrupt action fires on both crossing directions
// R11: read-only flag shows compared voltage below level
// R12: detector reset sets its reset cause flag
// R13: sixteen level codes drive the supply comparator
// R14: detector compares only when enabled, flag zero otherwise
// R15: level code in bits 3..0, upper bits zero
// R16: non-detector resets clear control and level registers
// R17: power-on clear zeroes whole reset cause register
// R18: comparator outputs pass two-stage synchroniser first
// R19: detector keeps working while processor clock stopped
module pcl_top
#(
    parameter logic [16:0] STAB_CYCLES = pcl_pkg::STAB_CYCLES
)
(
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    input  wire logic                        clk_en,
    input  wire pcl_pkg::pcl_analog_type     analog_in,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic                             pready,
    output logic                             pslverr,
    output logic [31:0]                      prdata,
    output logic                             internal_reset_n,
    output logic                             irq,
    output logic                             detector_enable,
    output logic                             detect_source_select,
    output logic [pcl_pkg::LEVEL_W-1:0]      supply_detect_level
);

    // ****************************************************************
    // synchronised comparator and request levels
    // ****************************************************************
    pcl_pkg::pcl_analog_type sync_in;

    pcl_sync u_sync                                         // R18
    (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .d       (analog_in),
        .q       (sync_in)
    );

    pcl_pkg::pcl_state_type state_reg;
    pcl_pkg::pcl_state_type state_next;

    logic        por_hold;
    logic        other_hold;
    logic        below;
    logic        lvd_reset;
    logic        compare_ok;
    logic        access;
    logic        complete;
    logic        addr_hit;
    logic [7:0]  ofs;
    logic [31:0] rd_value;
    logic [7:0]  wr_byte;
    logic        wr_en;

    // ****************************************************************
    // live comparison
    // ****************************************************************
    always_comb
    begin
        compare_ok = state_reg.ctrl[pcl_pkg::CTRL_SRC_BIT] ?           // R06
                     sync_in.pin_ok : sync_in.supply_ok;
        // disabled detector reads as not below
        below      = state_reg.ctrl[pcl_pkg::CTRL_EN_BIT] && !compare_ok; // R14
        lvd_reset  = below && state_reg.ctrl[pcl_pkg::CTRL_ACT_BIT];      // R07 R08 R09
        por_hold   = (state_reg.poc_state != pcl_pkg::POC_RUN);
        other_hold = sync_in.ext_reset_req || sync_in.wdt_reset_req;
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    always_comb
    begin
        ofs      = paddr[pcl_pkg::ADDR_W-1:0];
        access   = psel && penable;
        complete = access && state_reg.pready;
        wr_byte  = pwdata[7:0];
        wr_en    = complete && pwrite && pstrb[0] && !state_reg.pslverr;
        addr_hit = (paddr[31:pcl_pkg::ADDR_W] == '0) && (paddr[1:0] == 2'b00);
        rd_value = 32'h0000_0000;
        unique case (ofs)
            pcl_pkg::OFS_CTRL:
            begin
                rd_value[7:0] = state_reg.ctrl;
                rd_value[pcl_pkg::CTRL_FLAG_BIT] = below;                // R11
            end
            pcl_pkg::OFS_LEVEL:
            begin
                rd_value[pcl_pkg::LEVEL_W-1:0] = state_reg.level;        // R15
            end
            pcl_pkg::OFS_CAUSE:
            begin
                rd_value[7:0] = state_reg.cause;
            end
            pcl_pkg::OFS_INT_STATUS:
            begin
                rd_value[pcl_pkg::INT_W-1:0] = state_reg.int_status;
            end
            pcl_pkg::OFS_INT_MASK:
            begin
                rd_value[pcl_pkg::INT_W-1:0] = state_reg.int_mask;
            end
            pcl_pkg::OFS_POC_STATUS:
            begin
                rd_value[pcl_pkg::POC_MODE_BIT] = state_reg.por_mode;
            end
            default:
            begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;

        // power-on clear sequencer, never gated by the clock enable
        unique case (state_reg.poc_state)
            pcl_pkg::POC_WAIT_LOW:
            begin
                // option is caught while held, before any release
                state_next.por_mode = sync_in.por_mode_option;
                state_next.stab_cnt = '0;
                if (sync_in.por_low_ok)
                begin
                    if (sync_in.por_mode_option)
                    begin
                        state_next.poc_state = pcl_pkg::POC_STAB;        // R03
                    end
                    else
                    begin
                        state_next.poc_state = pcl_pkg::POC_RUN;         // R01
                    end
                end
            end
            pcl_pkg::POC_STAB:
            begin
                if (!sync_in.por_low_ok)
                begin
                    state_next.poc_state = pcl_pkg::POC_WAIT_LOW;
                end
                else
                begin
                    if (state_reg.stab_cnt != STAB_CYCLES)
                    begin
                        state_next.stab_cnt = state_reg.stab_cnt + 1'b1; // R05
                    end
                    // full wait even on a fast rise to the high point
                    if ((state_reg.stab_cnt == STAB_CYCLES) && sync_in.por_high_ok)
                    begin
                        state_next.poc_state = pcl_pkg::POC_RUN;         // R04 R05
                    end
                end
            end
            pcl_pkg::POC_RUN:
            begin
                if (!sync_in.por_low_ok)
                begin
                    state_next.poc_state = pcl_pkg::POC_WAIT_LOW;        // R02 R04
                end
            end
        endcase

        // bus side, frozen while the clock enable is low
        if (clk_en)
        begin
            state_next.pready  = access && !state_reg.pready;
            state_next.pslverr = access && !state_reg.pready && !addr_hit;
            if (access && !state_reg.pready)
            begin
                state_next.prdata = rd_value;
            end
            if (wr_en)
            begin
                unique case (ofs)
                    pcl_pkg::OFS_CTRL:
                    begin
                        state_next.ctrl = wr_byte & pcl_pkg::CTRL_WR_MASK;
                    end
                    pcl_pkg::OFS_LEVEL:
                    begin
                        state_next.level = wr_byte[pcl_pkg::LEVEL_W-1:0]; // R13 R15
                    end
                    pcl_pkg::OFS_INT_STATUS:
                    begin
                        state_next.int_status = state_reg.int_status &
                                                ~wr_byte[pcl_pkg::INT_W-1:0];
                    end
                    pcl_pkg::OFS_INT_MASK:
                    begin
                        state_next.int_mask = wr_byte[pcl_pkg::INT_W-1:0];
                    end
                    default:
                    begin
                        state_next.int_mask = state_next.int_mask;
                    end
                endcase
            end
            // reading the cause register empties it
            if (complete && !pwrite && (ofs == pcl_pkg::OFS_CAUSE) && addr_hit)
            begin
                state_next.cause = pcl_pkg::CAUSE_RST;
            end
        end

        // interrupt action: both crossings, detected on the live level
        state_next.below_prev = below;
        if (!state_reg.ctrl[pcl_pkg::CTRL_ACT_BIT] && (below != state_reg.below_prev))
        begin
            if (below)
            begin
                state_next.int_status[pcl_pkg::INT_FALL_BIT] = 1'b1;    // R10
            end
            else
            begin
                state_next.int_status[pcl_pkg::INT_RISE_BIT] = 1'b1;    // R10
            end
        end

        // watchdog: clears control, keeps detector cause, marks itself
        if (sync_in.wdt_reset_req)
        begin
            state_next.ctrl       = pcl_pkg::CTRL_RST;                  // R16
            state_next.level      = pcl_pkg::LEVEL_RST;                 // R16
            state_next.int_status = pcl_pkg::INT_RST;
            state_next.int_mask   = pcl_pkg::INT_RST;
            state_next.cause[pcl_pkg::CAUSE_WDT_BIT] = 1'b1;
        end

        // power-on clear and external reset wipe control, level, cause and both interrupt registers
        if (por_hold || sync_in.ext_reset_req)
        begin
            state_next.ctrl       = pcl_pkg::CTRL_RST;                  // R16
            state_next.level      = pcl_pkg::LEVEL_RST;                 // R16
            state_next.cause      = pcl_pkg::CAUSE_RST;                 // R17
            state_next.int_status = pcl_pkg::INT_RST;
            state_next.int_mask   = pcl_pkg::INT_RST;
            state_next.below_prev = 1'b0;
        end

        // detector reset leaves control and level alone; set beats read clear
        if (lvd_reset && !por_hold)
        begin
            state_next.cause[pcl_pkg::CAUSE_LVD_BIT] = 1'b1;            // R12
        end

        // detector paths use only sys_clk, which keeps running in stop
        state_next.rst_n_out = !(por_hold || lvd_reset || other_hold); // R19
        state_next.irq       = |(state_next.int_status & state_next.int_mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg            <= '0;
            state_reg.ctrl       <= pcl_pkg::CTRL_RST;
            state_reg.level      <= pcl_pkg::LEVEL_RST;
            state_reg.cause      <= pcl_pkg::CAUSE_RST;
            state_reg.int_status <= pcl_pkg::INT_RST;
            state_reg.int_mask   <= pcl_pkg::INT_RST;
            state_reg.prdata     <= pcl_pkg::RDATA_RST;
            state_reg.rst_n_out  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs straight from the state register
    // ****************************************************************
    assign pready               = state_reg.pready;
    assign pslverr              = state_reg.pslverr;
    assign prdata               = state_reg.prdata;
    assign internal_reset_n     = state_reg.rst_n_out;
    assign irq                  = state_reg.irq;
    assign detector_enable      = state_reg.ctrl[pcl_pkg::CTRL_EN_BIT];
    assign detect_source_select = state_reg.ctrl[pcl_pkg::CTRL_SRC_BIT];
    assign supply_detect_level  = state_reg.level;                     // R13

endmodule

// *** verif/pcl_props.sv ***
`timescale 1ns/1ps

module pcl_props
#(
    parameter logic [16:0] STAB_CYCLES = pcl_pkg::STAB_CYCLES
)
(
    input wire logic                        sys_clk,
    input wire logic                        arst_n,
    input wire logic                        clk_en,
    input wire pcl_pkg::pcl_analog_type     analog_in,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [31:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [31:0]                 prdata,
    input wire logic                        internal_reset_n,
    input wire logic                        irq,
    input wire logic                        detector_enable,
    input wire logic                        detect_source_select,
    input wire logic [pcl_pkg::LEVEL_W-1:0] supply_detect_level
);
    // ********
    // helpers
    // ********
    logic [16:0] up_cnt;
    logic        wr_ok;

    // write checks only count writes made outside internal reset
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr && internal_reset_n;

    // saturates, so it never wraps under the wait
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            up_cnt <= 17'h0_0000;
        else if (!analog_in.por_low_ok)
            up_cnt <= 17'h0_0000;
        else if (up_cnt != 17'h1_FFFF)
            up_cnt <= up_cnt + 17'h0_0001;
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_access;
        psel && $rose(penable) && clk_en;
    endsequence

    sequence s_one_wait;
        !pready ##1 pready;
    endsequence

    a_poc_hold: assert property (
        !analog_in.por_low_ok [*5] |-> !internal_reset_n) else $error("reset not held");
    a_release_low: assert property (
        $rose(internal_reset_n) |-> $past(analog_in.por_low_ok, 3)) else $error("early release");
    a_release_high: assert property (
        $rose(internal_reset_n) && analog_in.por_mode_option |-> $past(analog_in.por_high_ok, 3))
        else $error("release below high point");
    a_stab_wait: assert property (
        $rose(internal_reset_n) && analog_in.por_mode_option |-> up_cnt >= STAB_CYCLES)
        else $error("wait too short");
    a_poc_clears: assert property (
        !analog_in.por_low_ok [*5] |-> !detector_enable && !detect_source_select
        && supply_detect_level == 4'h0) else $error("registers not cleared");
    a_level_write: assert property (
        wr_ok && paddr == {24'h00_0000, pcl_pkg::OFS_LEVEL}
        |=> supply_detect_level == $past(pwdata[3:0])) else $error("level not applied");
    a_ctrl_write: assert property (
        wr_ok && paddr == {24'h00_0000, pcl_pkg::OFS_CTRL}
        |=> detector_enable == $past(pwdata[7]) && detect_source_select == $past(pwdata[2]))
        else $error("control not applied");
    a_bus_wait: assert property (
        s_access |-> s_one_wait) else $error("wrong wait states");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready longer than one cycle");
    a_unmapped_err: assert property (
        psel && penable && pready && !pwrite && paddr == 32'h0000_0040
        |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped read accepted");
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps

module tb;
    localparam logic [16:0]  STAB = 17'h0_0014;
    logic                    sys_clk;
    logic                    arst_n;
    logic                    clk_en;
    pcl_pkg::pcl_analog_type analog_in;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             paddr;
    logic [31:0]             pwdata;
    logic [3:0]              pstrb;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    internal_reset_n;
    logic                    irq;
    logic                    detector_enable;
    logic                    detect_source_select;
    logic [3:0]              supply_detect_level;
    logic [31:0]             rd;
    logic                    err;
    logic [7:0]              v;
    int                      fail_count;
    int                      compares;
    int                      k;

    pcl_top #(.STAB_CYCLES(STAB)) pcl_top_inst
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .analog_in(analog_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .internal_reset_n(internal_reset_n), .irq(irq), .detector_enable(detector_enable),
        .detect_source_select(detect_source_select), .supply_detect_level(supply_detect_level)
    );

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // ********
    // tasks
    // ********
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // waits for pready at an edge, no latency assumed
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic wrst(input logic exp);
        int n;
        n = 0;
        while (internal_reset_n !== exp && n < 12)
        begin
            step(1);
            n++;
        end
        chk(32'(internal_reset_n), 32'(exp));
    endtask

    task automatic clr;
        apb(pcl_pkg::OFS_INT_STATUS, 1'b1, 32'h0000_0003);
        step(2);
        chk(32'(irq), 32'h0000_0000);
    endtask

    task automatic conclude;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        #(100 * 10000);
        fail_count++;
        conclude();
    end

    // ********
    // sequence
    // ********
    initial
    begin
        k = $urandom(32'hcdf4_c160);
        fail_count = 0;
        compares = 0;
        {arst_n, psel, penable, pwrite, clk_en} = 5'h01;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h1;
        analog_in = 7'h0E;
        step(5);
        arst_n <= 1'b1;
        step(8);
        chk(32'(internal_reset_n), 32'h0000_0000);
        analog_in.por_low_ok <= 1'b1;
        wrst(1'b1);
        for (k = 0; k < 6; k++)
            rchk(8'(k * 4), 32'h0000_0000);
        apb(8'h40, 1'b0, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        for (k = 0; k < 16; k++)
        begin
            apb(pcl_pkg::OFS_LEVEL, 1'b1, {28'($urandom), 4'(k)});
            rchk(pcl_pkg::OFS_LEVEL, 32'(k));
            chk(32'(supply_detect_level), 32'(k));
        end
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_00FF);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0086);
        chk(32'({detector_enable, detect_source_select}), 32'h0000_0003);
        // interrupt action: masked fall, then both directions
        apb(pcl_pkg::OFS_INT_MASK, 1'b1, 32'h0000_0002);
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0080);
        analog_in.supply_ok <= 1'b0;
        step(6);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0081);
        rchk(pcl_pkg::OFS_INT_STATUS, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        apb(pcl_pkg::OFS_INT_MASK, 1'b1, 32'h0000_0003);
        step(2);
        chk(32'(irq), 32'h0000_0001);
        analog_in.supply_ok <= 1'b1;
        step(6);
        rchk(pcl_pkg::OFS_INT_STATUS, 32'h0000_0003);
        clr();
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0084);
        analog_in.pin_ok <= 1'b0;
        step(6);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0085);
        analog_in.pin_ok <= 1'b1;
        step(6);
        clr();
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0000);
        analog_in.supply_ok <= 1'b0;
        step(6);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0000);
        analog_in.supply_ok <= 1'b1;
        // bus frozen: detection still raises irq
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0080);
        clk_en <= 1'b0;
        analog_in.supply_ok <= 1'b0;
        step(6);
        chk(32'(irq), 32'h0000_0001);
        clk_en <= 1'b1;
        analog_in.supply_ok <= 1'b1;
        step(6);
        clr();
        // reset action: supply then pin, then watchdog, power-on and external resets
        v = 8'($urandom % 16);
        apb(pcl_pkg::OFS_LEVEL, 1'b1, 32'(v));
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0082);
        analog_in.supply_ok <= 1'b0;
        wrst(1'b0);
        analog_in.supply_ok <= 1'b1;
        wrst(1'b1);
        rchk(pcl_pkg::OFS_CAUSE, 32'h0000_0001);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0082);
        rchk(pcl_pkg::OFS_LEVEL, 32'(v));
        apb(pcl_pkg::OFS_CTRL, 1'b1, 32'h0000_0086);
        analog_in.pin_ok <= 1'b0;
        wrst(1'b0);
        analog_in.pin_ok <= 1'b1;
        wrst(1'b1);
        rchk(pcl_pkg::OFS_CAUSE, 32'h0000_0001);
        analog_in.wdt_reset_req <= 1'b1;
        wrst(1'b0);
        analog_in.wdt_reset_req <= 1'b0;
        wrst(1'b1);
        rchk(pcl_pkg::OFS_CTRL, 32'h0000_0000);
        rchk(pcl_pkg::OFS_LEVEL, 32'h0000_0000);
        analog_in.por_low_ok <= 1'b0;
        wrst(1'b0);
        analog_in.por_low_ok <= 1'b1;
        wrst(1'b1);
        rchk(pcl_pkg::OFS_CAUSE, 32'h0000_0000);
        analog_in.ext_reset_req <= 1'b1;
        wrst(1'b0);
        analog_in.ext_reset_req <= 1'b0;
        wrst(1'b1);
        // dual-threshold power-up with hysteresis
        arst_n <= 1'b0;
        analog_in <= 7'h1C;
        step(5);
        arst_n <= 1'b1;
        analog_in.por_low_ok <= 1'b1;
        step(40);
        chk(32'(internal_reset_n), 32'h0000_0000);
        analog_in.por_low_ok <= 1'b0;
        step(4);
        analog_in <= 7'h1F;
        k = 0;
        while (internal_reset_n !== 1'b1 && k < 60)
        begin
            step(1);
            k++;
        end
        chk(32'(k > STAB && k < 40), 32'h0000_0001);
        analog_in.por_high_ok <= 1'b0;
        step(10);
        chk(32'(internal_reset_n), 32'h0000_0001);
        analog_in.por_low_ok <= 1'b0;
        wrst(1'b0);
        analog_in.por_low_ok <= 1'b1;
        step(40);
        chk(32'(internal_reset_n), 32'h0000_0000);
        conclude();
    end
endmodule

bind pcl_top pcl_props #(.STAB_CYCLES(STAB_CYCLES)) pcl_props_inst
(
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .analog_in(analog_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .internal_reset_n(internal_reset_n), .irq(irq), .detector_enable(detector_enable),
    .detect_source_select(detect_source_select), .supply_detect_level(supply_detect_level)
);
